// ### hw/agctp_pkg.sv
package agctp_pkg;

  // ****************************************
  // clock and time base
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 500;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int TW     = 22;
  localparam int GAIN_W = 7;
  localparam int CODE_W = 4;

  // ****************************************
  // register indexes, byte address is index times four
  // ****************************************
  localparam logic [7:0] IDX_CTRL   = 8'h15;
  localparam logic [7:0] IDX_TIMING = 8'h16;
  localparam logic [7:0] IDX_HOLD   = 8'h17;
  localparam logic [7:0] IDX_START  = 8'h18;
  localparam logic [7:0] IDX_STEP   = 8'h1A;
  localparam logic [7:0] IDX_GAIN   = 8'h20;
  localparam logic [7:0] IDX_STATUS = 8'h21;

  // ****************************************
  // field positions
  // ****************************************
  localparam int REC_LSB     = 4;
  localparam int RED_LSB     = 0;
  localparam int ZTO_LSB     = 4;
  localparam int HOLD_LSB    = 0;
  localparam int START_LSB   = 0;
  localparam int START_W     = 3;
  localparam int EN_BIT      = 0;
  localparam int ZC_BIT      = 7;
  localparam int JUMP_UP_BIT = 1;
  localparam int STEP_DN_BIT = 0;
  localparam int STAT_SU_BIT = 8;
  localparam int STAT_BZ_BIT = 9;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0]         CTRL_RST   = 8'h00;
  localparam logic [7:0]         TIMING_RST = 8'h10;
  localparam logic [7:0]         HOLD_RST   = 8'h00;
  localparam logic [START_W-1:0] START_RST  = 3'h0;
  localparam logic [7:0]         STEP_RST   = 8'h0C;
  localparam logic [7:0]         GAIN_RST   = 8'h0C;

  // ****************************************
  // period tables in 500 ns ticks, index is the field code
  // ****************************************
  typedef logic [TW-1:0] agctp_tab_t [16];
  localparam agctp_tab_t REC_TICKS = '{
    22'h0, 22'h3E8, 22'h7D0, 22'hFA0, 22'h1F40, 22'h3E80, 22'h4E20, 22'h5DC0,
    22'h7D00, 22'h9C40, 22'hBB80, 22'hDAC0, 22'hFA00, 22'h1F400, 22'h7D000, 22'h7D000};
  localparam agctp_tab_t RED_TICKS = '{
    22'h1, 22'h2, 22'h4, 22'h8, 22'h10, 22'h18, 22'h20, 22'h30,
    22'h40, 22'h80, 22'h100, 22'h200, 22'h400, 22'h7D0, 22'hFA0, 22'h1F40};
  localparam agctp_tab_t ZTO_TICKS = '{
    22'h0, 22'h9C40, 22'h13880, 22'h27100, 22'h3A980, 22'h4E200, 22'h75300, 22'h9C400,
    22'hC3500, 22'hEA600, 22'h111700, 22'h138800, 22'h186A00, 22'h1D4C00, 22'h271000,
    22'h271000};
  localparam agctp_tab_t HOLD_TICKS = '{
    22'h0, 22'h9C40, 22'h13880, 22'h27100, 22'h3A980, 22'h4E200, 22'h75300, 22'h9C400,
    22'hC3500, 22'hEA600, 22'h111700, 22'h138800, 22'h186A00, 22'h1D4C00, 22'h222E00,
    22'h271000};
  typedef logic [TW-1:0] agctp_stab_t [8];
  localparam agctp_stab_t START_TICKS = '{
    22'h7D0, 22'hFA0, 22'h1F40, 22'h3E80, 22'h7D00, 22'hFA00, 22'h3E800, 22'h3E800};

  // ****************************************
  // gain sequencer states
  // ****************************************
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_STEP  = 5'b00010,
    ST_ZWAIT = 5'b00100,
    ST_HOLD  = 5'b01000,
    ST_SPARE = 5'b10000
  } agctp_state_t;

endpackage

// ### hw/agctp_timer.sv
`timescale 1ns/1ns
module agctp_timer #(
  parameter int TW = agctp_pkg::TW
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          start,
  input  wire logic          tick,
  input  wire logic [TW-1:0] period,
  output logic               done,
  output logic               busy
);
  import agctp_pkg::*;

  if (TW < 1) begin : g_bad_tw
    $error("agctp_timer: TW must be at least 1");
  end

  typedef struct packed {
    logic          busy;
    logic          done;
    logic [TW-1:0] cnt;
    logic [TW-1:0] per;
  } agctp_tmr_t;

  agctp_tmr_t q, d;

  // ****************************************
  // interval counter, period latched at start
  // ****************************************
  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (start) begin
      d.busy = 1'b1;
      d.cnt  = '0;
      d.per  = period;
    end else if (q.busy) begin
      if (q.cnt >= q.per) begin
        d.done = 1'b1;
        d.busy = 1'b0;
      end else if (tick) begin
        d.cnt = q.cnt + TW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;
  assign busy = q.busy;

endmodule // agctp_timer

// ### hw/agctp_top.sv
// Summary of operation
// RULE_01 - The recovery period comes from bits 7:4 of the timing register, reset code 0001 (0.5 ms).
// RULE_02 - Recovery codes map 0000 to 0 ms, then 0.5 to 32 ms in the listed steps, 1101 64 ms, 1111 256 ms.
// RULE_03 - The reduction period comes from bits 3:0 of the timing register, reset code 0000 (0.5 us).
// RULE_04 - Reduction codes 0000 to 1111 map to 0.5 us up to 4000 us in the listed steps.
// RULE_05 - The zero-crossing wait limit is bits 7:4 of the hold register, reset 0000 meaning no timeout.
// RULE_06 - Wait limit codes 0001 to 1101 give 20 to 960 ms, and 1111 gives 1280 ms.
// RULE_07 - The dwell time is bits 3:0 of the hold register, reset 0000 meaning no dwell.
// RULE_08 - Dwell codes 0001 to 1111 give 20 ms up to 1280 ms in the listed steps.
// RULE_09 - Bits 2:0 of the startup register, reset 000, pace gain ramp-up steps only during startup.
// RULE_10 - Startup step codes 000 to 101 give 1 to 32 ms per step and 111 gives 128 ms per step.
// RULE_11 - Reserved codes 1110 (recovery, wait limit) and 110 (startup) act as the next larger code.
// RULE_12 - All periods are counted from one time base and a new value applies from the next interval.
// RULE_13 - Level driven gain control runs only while the enable bit 0 of the control register is set.
// RULE_14 - Zero-crossing waiting happens only while bit 7 of the control register is set.
// RULE_15 - A host raise without immediate raise steps up one code per recovery period.
// RULE_16 - A host lower with stepping down set steps down one code per reduction period.
`timescale 1ns/1ns
module agctp_top #(
  parameter int TICK_CYCLES = agctp_pkg::TICK_CYCLES,
  parameter int GAIN_W      = agctp_pkg::GAIN_W
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [agctp_pkg::ADDR_W-1:0] paddr,
  input  wire logic [agctp_pkg::DATA_W-1:0] pwdata,
  output logic                              pready,
  output logic      [agctp_pkg::DATA_W-1:0] prdata,
  output logic                              pslverr,
  input  wire logic                         over_level,
  input  wire logic                         under_level,
  input  wire logic                         zero_cross,
  output logic      [GAIN_W-1:0]            gain_out,
  output logic                              gain_update,
  output logic                              startup_active
);
  import agctp_pkg::*;

  if (TICK_CYCLES < 1 || GAIN_W < 1 || GAIN_W > 8) begin : g_bad_param
    $error("agctp_top: TICK_CYCLES must be >= 1 and GAIN_W within 1..8");
  end

  localparam int TCW = $clog2(TICK_CYCLES + 1);

  localparam logic [ADDR_W-1:0] ADDR_CTRL   = ADDR_W'({IDX_CTRL, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_TIMING = ADDR_W'({IDX_TIMING, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_HOLD   = ADDR_W'({IDX_HOLD, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_START  = ADDR_W'({IDX_START, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_STEP   = ADDR_W'({IDX_STEP, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_GAIN   = ADDR_W'({IDX_GAIN, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'({IDX_STATUS, 2'b00});

  typedef struct packed {
    logic [7:0]         ctrl;
    logic [7:0]         timing;
    logic [7:0]         hold;
    logic [7:0]         step;
    logic [START_W-1:0] start;
    logic [GAIN_W-1:0]  goal;
    logic [GAIN_W-1:0]  gain;
    agctp_state_t       st;
    logic               dir_up;
    logic               startup;
    logic               host_raise;
    logic               upd;
    logic [TCW-1:0]     tick_cnt;
    logic [DATA_W-1:0]  rdata;
    logic               err;
  } agctp_top_t;

  agctp_top_t q, d;

  logic          tick;
  logic          tmr_start;
  logic [TW-1:0] tmr_period;
  logic          tmr_done;
  logic          tmr_busy;
  logic          apb_setup;
  logic          apb_access;

  // ****************************************
  // decoded fields
  // ****************************************
  logic [CODE_W-1:0] rec_code;
  logic [CODE_W-1:0] red_code;
  logic [CODE_W-1:0] zto_code;
  logic [CODE_W-1:0] hold_code;
  logic              agc_on;
  logic              zc_on;
  logic              jump_up;
  logic              step_dn;

  assign rec_code  = q.timing[REC_LSB +: CODE_W]; // RULE_01
  assign red_code  = q.timing[RED_LSB +: CODE_W]; // RULE_03
  assign zto_code  = q.hold[ZTO_LSB +: CODE_W]; // RULE_05
  assign hold_code = q.hold[HOLD_LSB +: CODE_W]; // RULE_07
  assign agc_on    = q.ctrl[EN_BIT]; // RULE_13
  assign zc_on     = q.ctrl[ZC_BIT]; // RULE_14
  assign jump_up   = q.step[JUMP_UP_BIT];
  assign step_dn   = q.step[STEP_DN_BIT];

  assign tick       = (q.tick_cnt == '0); // RULE_12
  assign apb_setup  = psel & ~penable;
  assign apb_access = psel & penable;

  // ****************************************
  // shared interval timer
  // ****************************************
  agctp_timer #(
    .TW (TW)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (tmr_start),
    .tick    (tick),
    .period  (tmr_period),
    .done    (tmr_done),
    .busy    (tmr_busy)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic apply;
    apply      = 1'b0;
    d          = q;
    d.upd      = 1'b0;
    tmr_start  = 1'b0;
    tmr_period = '0;

    // time base
    if (tick) begin
      d.tick_cnt = TCW'(TICK_CYCLES - 1); // RULE_12
    end else begin
      d.tick_cnt = q.tick_cnt - TCW'(1);
    end

    // gain sequencer
    case (q.st)
      ST_IDLE: begin
        if (q.startup) begin
          if (q.gain < q.goal) begin
            d.dir_up   = 1'b1;
            tmr_start  = 1'b1;
            tmr_period = START_TICKS[q.start]; // RULE_09 RULE_10 RULE_11
            d.st       = ST_STEP;
          end else begin
            d.startup = 1'b0;
          end
        end else if (agc_on && over_level && q.gain != '0) begin
          d.dir_up     = 1'b0;
          d.host_raise = 1'b0;
          tmr_start    = 1'b1;
          tmr_period   = RED_TICKS[red_code]; // RULE_13 RULE_04
          d.st         = ST_STEP;
        end else if (q.gain > q.goal) begin
          if (step_dn) begin
            d.dir_up   = 1'b0;
            tmr_start  = 1'b1;
            tmr_period = RED_TICKS[red_code]; // RULE_16 RULE_04
            d.st       = ST_STEP;
          end else begin
            d.gain = q.goal;
            d.upd  = 1'b1;
          end
        end else if (q.gain < q.goal) begin
          if (q.host_raise && jump_up) begin
            d.gain       = q.goal;
            d.upd        = 1'b1;
            d.host_raise = 1'b0;
          end else if (q.host_raise || !agc_on || under_level) begin
            d.dir_up   = 1'b1;
            tmr_start  = 1'b1;
            tmr_period = REC_TICKS[rec_code]; // RULE_15 RULE_02 RULE_11
            d.st       = ST_STEP;
          end
        end else begin
          d.host_raise = 1'b0;
        end
      end
      ST_STEP: begin
        if (tmr_done) begin
          if (zc_on) begin
            tmr_start  = (zto_code != '0); // RULE_14 RULE_05
            tmr_period = ZTO_TICKS[zto_code]; // RULE_06 RULE_11
            d.st       = ST_ZWAIT;
          end else begin
            apply = 1'b1;
          end
        end
      end
      ST_ZWAIT: begin
        if (zero_cross || (zto_code != '0 && tmr_done)) begin
          apply = 1'b1; // RULE_05
        end
      end
      ST_HOLD: begin
        if (tmr_done) begin
          d.st = ST_IDLE;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // one gain code per applied step, then optional dwell
    if (apply) begin
      d.upd = 1'b1;
      if (q.dir_up) begin
        d.gain = q.gain + GAIN_W'(1);
      end else begin
        d.gain = q.gain - GAIN_W'(1);
      end
      if (agc_on && hold_code != '0) begin
        tmr_start  = 1'b1;
        tmr_period = HOLD_TICKS[hold_code]; // RULE_07 RULE_08
        d.st       = ST_HOLD;
      end else begin
        d.st = ST_IDLE;
      end
    end

    // register bus, read data and error latched in setup
    if (apb_setup) begin
      d.err   = 1'b0;
      d.rdata = '0;
      case (paddr)
        ADDR_CTRL:   d.rdata = DATA_W'(q.ctrl);
        ADDR_TIMING: d.rdata = DATA_W'(q.timing);
        ADDR_HOLD:   d.rdata = DATA_W'(q.hold);
        ADDR_START:  d.rdata = DATA_W'(q.start);
        ADDR_STEP:   d.rdata = DATA_W'(q.step);
        ADDR_GAIN:   d.rdata = DATA_W'(q.goal);
        ADDR_STATUS: begin
          d.rdata              = DATA_W'(q.gain);
          d.rdata[STAT_SU_BIT] = q.startup;
          d.rdata[STAT_BZ_BIT] = (q.st != ST_IDLE);
        end
        default:     d.err = 1'b1;
      endcase
    end

    if (apb_access && pwrite && !q.err) begin
      case (paddr)
        ADDR_CTRL:   d.ctrl   = pwdata[7:0];
        ADDR_TIMING: d.timing = pwdata[7:0]; // RULE_12
        ADDR_HOLD:   d.hold   = pwdata[7:0];
        ADDR_START:  d.start  = pwdata[START_LSB +: START_W];
        ADDR_STEP:   d.step   = pwdata[7:0];
        ADDR_GAIN: begin
          d.goal = pwdata[GAIN_W-1:0];
          if (pwdata[GAIN_W-1:0] > q.gain) begin
            d.host_raise = 1'b1; // RULE_15
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q            <= '0;
      q.ctrl       <= CTRL_RST;
      q.timing     <= TIMING_RST; // RULE_01 RULE_03
      q.hold       <= HOLD_RST;
      q.start      <= START_RST;
      q.step       <= STEP_RST;
      q.goal       <= GAIN_W'(GAIN_RST);
      q.st         <= ST_IDLE;
      q.startup    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign pready         = apb_access;
  assign prdata         = q.rdata;
  assign pslverr        = apb_access & q.err;
  assign gain_out       = q.gain;
  assign gain_update    = q.upd;
  assign startup_active = q.startup;

endmodule // agctp_top

// ### test/agctp_monitor.sv
`timescale 1ns/1ns
module agctp_monitor #(
  parameter int TICK_CYCLES = 1,
  parameter int GAIN_W      = 7
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic [GAIN_W-1:0] gain_out,
  input wire logic              gain_update,
  input wire logic              startup_active
);
  import agctp_pkg::*;
  // ****
  // bus and gain link checks
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_step;
    gain_update ##1 !gain_update;
  endsequence
  a_ready_access: assert property (s_access |-> pready)
    else $error("pready missing in access cycle");
  a_ready_only: assert property (pready |-> psel && penable)
    else $error("pready outside access cycle");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access cycle");
  a_err_data_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:10] == 22'h0)
    else $error("upper read bits not zero");
  a_change_pulse: assert property ($changed(gain_out) |-> gain_update)
    else $error("gain changed without update pulse");
  a_pulse_change: assert property (gain_update |-> $changed(gain_out))
    else $error("update pulse without gain change");
  a_pulse_single: assert property (gain_update |-> s_step)
    else $error("update pulse longer than one cycle");
  a_ramp_up_one: assert property (startup_active && gain_update
    |-> gain_out == GAIN_W'($past(gain_out) + 1'b1))
    else $error("startup step not one code up");
  a_ramp_once: assert property (!startup_active |=> !startup_active)
    else $error("startup ramp restarted");
endmodule // agctp_monitor

// ### test/tb.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin miscompares++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb;
  import agctp_pkg::*;
  // ****
  // signals and tables
  // ****
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} agctp_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        over_level, under_level, zero_cross, gain_update, startup_active, er;
  logic [6:0]  gain_out;
  int          miscompares, compares, n;
  int          red_t [16] = '{1, 2, 4, 8, 16, 24, 32, 48, 64, 128, 256, 512, 1024, 2000, 4000,
                              8000};
  int          rec_t [4]  = '{0, 1000, 2000, 4000};
  agctp_row_t  rows [11]  = '{
    '{1'b0, 12'h058, 32'h0, 32'h10, 1'b0}, '{1'b0, 12'h05C, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h060, 32'h0, 32'h0, 1'b0}, '{1'b1, 12'h058, 32'hA5, 32'h0, 1'b0},
    '{1'b0, 12'h058, 32'h0, 32'hA5, 1'b0}, '{1'b1, 12'h05C, 32'h3C, 32'h0, 1'b0},
    '{1'b0, 12'h05C, 32'h0, 32'h3C, 1'b0}, '{1'b1, 12'h064, 32'h1, 32'h0, 1'b1},
    '{1'b0, 12'h064, 32'h0, 32'h0, 1'b1}, '{1'b1, 12'h058, 32'h10, 32'h0, 1'b0},
    '{1'b1, 12'h05C, 32'h0, 32'h0, 1'b0}};
  agctp_top #(.TICK_CYCLES(1)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .over_level(over_level), .under_level(under_level),
    .zero_cross(zero_cross), .gain_out(gain_out), .gain_update(gain_update),
    .startup_active(startup_active));
  // ****
  // tasks
  // ****
  task automatic complete_run;
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_upd(input int lim);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (gain_update !== 1'b1 && n < lim);
    @(posedge pclk);
  endtask
  task automatic step_chk(input logic [6:0] tgt, input int t);
    apb(1'b1, 12'h080, {25'h0, tgt});
    wait_upd(t + 40);
    `CHK("step_cycles", t, (n >= t - 1 && n <= t + 3) ? t : n)
    `CHK("step_gain", tgt, gain_out)
  endtask
  // ****
  // sequence
  // ****
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    repeat (80000) @(posedge pclk);
    miscompares++;
    complete_run;
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    over_level = 1'b0; under_level = 1'b0; zero_cross = 1'b0; miscompares = 0; compares = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) `CHK("rdata", rows[i].x, rd)
      `CHK("slverr", rows[i].e, er)
    end
    wait_upd(2200);
    wait_upd(2200);
    `CHK("ramp_step", 2000, (n >= 1999 && n <= 2003) ? 2000 : n)
    n = 0;
    while (startup_active !== 1'b0 && n < 30000) begin
      @(negedge pclk);
      n++;
    end
    @(posedge pclk);
    `CHK("ramp_done", 1'b0, startup_active)
    `CHK("ramp_end", 7'h0C, gain_out)
    apb(1'b1, 12'h068, 32'h1);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 12'h058, c << 4);
      step_chk(7'h0D + c[6:0], rec_t[c]);
    end
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, 12'h058, c);
      step_chk(7'h0F - c[6:0], red_t[c]);
    end
    apb(1'b1, 12'h054, 32'h80);
    apb(1'b1, 12'h080, 32'h1);
    repeat (200) @(posedge pclk);
    `CHK("zc_wait", 7'h00, gain_out)
    zero_cross <= 1'b1;
    @(posedge pclk);
    zero_cross <= 1'b0;
    wait_upd(8);
    `CHK("zc_gain", 7'h01, gain_out)
    apb(1'b1, 12'h054, 32'h0);
    over_level <= 1'b1;
    repeat (100) @(posedge pclk);
    `CHK("agc_off", 7'h01, gain_out)
    apb(1'b1, 12'h058, 32'h0);
    apb(1'b1, 12'h054, 32'h1);
    wait_upd(16);
    `CHK("agc_on", 7'h00, gain_out)
    over_level <= 1'b0;
    apb(1'b1, 12'h068, 32'h2);
    apb(1'b1, 12'h080, 32'h5);
    wait_upd(8);
    `CHK("jump_up", 7'h05, gain_out)
    apb(1'b1, 12'h080, 32'h2);
    wait_upd(8);
    `CHK("jump_down", 7'h02, gain_out)
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("rst_gain", 7'h00, gain_out)
    `CHK("rst_startup", 1'b1, startup_active)
    presetn <= 1'b1;
    apb(1'b0, 12'h058, 32'h0);
    `CHK("rst_timing", 32'h10, rd)
    apb(1'b0, 12'h054, 32'h0);
    `CHK("rst_ctrl", 32'h0, rd)
    complete_run;
  end
endmodule // tb
bind agctp_top agctp_monitor #(.TICK_CYCLES(TICK_CYCLES), .GAIN_W(GAIN_W)) mon_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .gain_out(gain_out),
  .gain_update(gain_update), .startup_active(startup_active));
